// [asps_pkg.sv]
package asps_pkg;

  // Clock polarity and phase choices, in order of their control value
  typedef enum logic [1:0] {
    PROTO_00,
    PROTO_01,
    PROTO_10,
    PROTO_11
  } asps_proto_t;

  localparam int WORD_W = 32;
  localparam int RES_W = 14;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [5:0] STEP_SINGLE = 6'h01;
  localparam logic [5:0] STEP_DUAL = 6'h02;

  // Output mode and second output settings
  localparam logic [1:0] OUT_LEGACY = 2'h0;
  localparam logic [1:0] SEC_OUT_DUAL = 2'h3;
  localparam logic CLK_SRC_INTERNAL = 1'h1;

  // Write command layout inside a captured 32-bit frame
  localparam logic [6:0] CMD_WRITE_HWORD = 7'h68;
  localparam int CMD_OP_LSB = 25;
  localparam int CMD_ADDR_LSB = 17;
  localparam logic [7:0] ADDR_INPUT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_OUTPUT_CTRL = 8'h06;

  // Field positions inside the 16-bit write data
  localparam int IN_PROTO_LSB = 0;
  localparam int OUT_PROTO_LSB = 0;
  localparam int CLK_SRC_BIT = 6;
  localparam int SEC_CFG_LSB = 8;

  // Output word packing
  localparam logic [5:0] RES_LSB = 6'h12;
  localparam logic [5:0] ADDR_TAG_W = 6'h04;
  localparam logic [5:0] SUP_TAG_W = 6'h02;
  localparam logic [5:0] INALM_TAG_W = 6'h02;
  localparam logic [5:0] RANGE_TAG_W = 6'h04;
  localparam logic [5:0] PAR_TAG_W = 6'h02;

  // Reset values
  localparam logic [1:0] RST_OUT_PROTO = 2'h0;
  localparam logic [1:0] RST_SEC_CFG = 2'h0;
  localparam logic RST_CLK_SRC = 1'h0;

endpackage

// [asps_sync.sv]
`timescale 1ns/1ps
module asps_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // asps_sync

// [asps_protocol_select.sv]
// Behaviour
// - Pack result, supply alarm, range, parity MSB-first
// - Writes use four legacy polarity/phase protocols
// - Idle level and capture edge per protocol
// - First read bit launch edge per protocol
// - Reset restores protocol 00 everywhere
// - Chosen protocol governs reads and writes
// - Output mode 00 keeps legacy reads
// - Legacy protocols hold ready pin low
// - Word shifted MSB first, short frames allowed
// - Long legacy single-width frame passes input through
// - Dual mode launches two bits per edge
// - Source-synchronous mode drives output clock
// - Clock source bit picks serial or internal
// - Dual width also in source-synchronous mode
// - Writes only through legacy protocols
// - Configuration applies at frame-ending select rise
`timescale 1ns/1ps
module asps_protocol_select (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic convert_select_pin,
  input wire logic serial_data_in,
  input wire logic [asps_pkg::RES_W-1:0] conv_result,
  input wire logic [3:0] device_addr,
  input wire logic [1:0] supply_alarm,
  input wire logic [1:0] input_alarm,
  input wire logic [3:0] input_range,
  input wire logic [1:0] parity_bits,
  input wire logic tag_address_en,
  input wire logic tag_supply_alarm_en,
  input wire logic tag_input_alarm_en,
  input wire logic tag_range_en,
  input wire logic tag_parity_en,
  input wire logic alarm_level,
  output logic data_out_line0,
  output logic data_out_line0_oe,
  output logic shared_alarm_out_pin,
  output logic ready_out_clock_pin,
  output logic [asps_pkg::WORD_W-1:0] cmd_word,
  output logic cmd_valid,
  output logic [1:0] input_protocol_sel,
  output logic [1:0] output_protocol_sel,
  output logic [1:0] second_output_cfg,
  output logic srcsync_clock_source
);

  asps_pkg::asps_proto_t in_proto_r;
  logic [1:0] out_proto_r, sec_cfg_r;
  logic clk_src_r, cs_s, cs_d_r, cs_rise, cs_fall;
  logic [asps_pkg::WORD_W-1:0] word_nxt, word_r, rx_r;
  logic [5:0] pos, step, cap_cnt_r, idx_r, int_idx_r, bit_idx;
  logic link_clr_r, link_clr, cap_inv, cpha, cap_clk;
  logic dual, legacy, src_int, daisy, daisy_r;
  logic launched_r, int_run_r, int_clk_r, blank, d0, d1, frame_ok;
  logic [7:0] cmd_addr;
  logic [15:0] cmd_data;

  asps_sync #(.WIDTH(1), .RESET_VAL(1'h1)) u_cs_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(convert_select_pin),
    .sync_out(cs_s)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cs_d_r <= 1'h1;
    end else begin
      cs_d_r <= cs_s;
    end
  end

  assign cs_rise = cs_s & ~cs_d_r;
  assign cs_fall = ~cs_s & cs_d_r;

  assign legacy = (out_proto_r == asps_pkg::OUT_LEGACY);
  assign dual = (sec_cfg_r == asps_pkg::SEC_OUT_DUAL);
  assign src_int = !legacy && (clk_src_r == asps_pkg::CLK_SRC_INTERNAL);
  assign daisy = legacy && !dual;
  assign step = dual ? asps_pkg::STEP_DUAL : asps_pkg::STEP_SINGLE;

  assign cap_inv = (in_proto_r == asps_pkg::PROTO_01)
                || (in_proto_r == asps_pkg::PROTO_10);
  // late launch for 01 and 11
  assign cpha = in_proto_r[0];
  assign cap_clk = link_clk ^ cap_inv;

  // flags appended in fixed order below the result
  always_comb begin
    word_nxt = {conv_result, 18'h00000};
    pos = asps_pkg::RES_LSB;
    if (tag_address_en) begin
      pos = pos - asps_pkg::ADDR_TAG_W;
      word_nxt = word_nxt | ({28'h0000000, device_addr} << pos);
    end
    if (tag_supply_alarm_en) begin
      pos = pos - asps_pkg::SUP_TAG_W;
      word_nxt = word_nxt | ({30'h00000000, supply_alarm} << pos);
    end
    if (tag_input_alarm_en) begin
      pos = pos - asps_pkg::INALM_TAG_W;
      word_nxt = word_nxt | ({30'h00000000, input_alarm} << pos);
    end
    if (tag_range_en) begin
      pos = pos - asps_pkg::RANGE_TAG_W;
      word_nxt = word_nxt | ({28'h0000000, input_range} << pos);
    end
    if (tag_parity_en) begin
      pos = pos - asps_pkg::PAR_TAG_W;
      word_nxt = word_nxt | ({30'h00000000, parity_bits} << pos);
    end
  end

  // Output word frozen while a frame is open
  always_ff @(posedge core_clk) begin
    if (reset) begin
      word_r <= '0;
    end else if (cs_s && cs_d_r) begin
      word_r <= word_nxt;
    end
  end

  // Clears the capture side once the core has taken the frame
  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_clr_r <= 1'h1;
    end else if (cs_rise) begin
      link_clr_r <= 1'h1;
    end else if (!cs_s) begin
      link_clr_r <= 1'h0;
    end
  end

  // Raw select gates the clear so the first edge is never lost
  assign link_clr = link_clr_r & convert_select_pin;

  always_ff @(posedge cap_clk or posedge link_clr) begin
    if (link_clr) begin
      rx_r <= '0;
      cap_cnt_r <= 6'h00;
    end else begin
      rx_r <= {rx_r[asps_pkg::WORD_W-2:0], serial_data_in};
      if (cap_cnt_r != asps_pkg::WORD_BITS) begin
        cap_cnt_r <= cap_cnt_r + 6'h01;
      end
    end
  end

  // advance output on the opposite edge
  always_ff @(negedge cap_clk or posedge convert_select_pin) begin
    if (convert_select_pin) begin
      idx_r <= 6'h00;
      launched_r <= 1'h0;
      daisy_r <= 1'h0;
    end else begin
      launched_r <= 1'h1;
      daisy_r <= rx_r[asps_pkg::WORD_W-1];
      if ((launched_r || !cpha) && idx_r < asps_pkg::WORD_BITS) begin
        idx_r <= idx_r + step;
      end
    end
  end

  // internal clock shifter at half core rate
  always_ff @(posedge core_clk) begin
    if (reset) begin
      int_run_r <= 1'h0;
      int_clk_r <= 1'h0;
      int_idx_r <= 6'h00;
    end else if (cs_fall && src_int) begin
      int_run_r <= 1'h1;
      int_clk_r <= 1'h0;
      int_idx_r <= 6'h00;
    end else if (cs_s || int_idx_r >= asps_pkg::WORD_BITS) begin
      int_run_r <= 1'h0;
      int_clk_r <= 1'h0;
    end else if (int_run_r) begin
      int_clk_r <= ~int_clk_r;
      if (int_clk_r) begin
        int_idx_r <= int_idx_r + step;
      end
    end
  end

  assign bit_idx = src_int ? int_idx_r : idx_r;
  assign blank = !src_int && cpha && !launched_r;

  always_comb begin
    d0 = 1'h0;
    d1 = 1'h0;
    if (!blank && bit_idx < asps_pkg::WORD_BITS) begin
      d0 = word_r[5'h1F - bit_idx[4:0]];
      if (bit_idx[4:0] != 5'h1F) begin
        d1 = word_r[5'h1E - bit_idx[4:0]];
      end
    end else if (!blank && daisy) begin
      d0 = daisy_r;
    end
  end

  assign data_out_line0_oe = ~convert_select_pin;
  assign data_out_line0 = data_out_line0_oe & d0;
  assign shared_alarm_out_pin = dual ? (data_out_line0_oe & d1)
                                     : alarm_level;

  // legacy keeps ready pin low; output clock otherwise
  assign ready_out_clock_pin = legacy ? 1'h0 :
                               src_int ? int_clk_r :
                               (link_clk & ~convert_select_pin);

  assign frame_ok = (cap_cnt_r == asps_pkg::WORD_BITS);
  assign cmd_addr = rx_r[asps_pkg::CMD_ADDR_LSB +: 8];
  assign cmd_data = rx_r[15:0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      in_proto_r <= asps_pkg::PROTO_00;
      out_proto_r <= asps_pkg::RST_OUT_PROTO;
      sec_cfg_r <= asps_pkg::RST_SEC_CFG;
      clk_src_r <= asps_pkg::RST_CLK_SRC;
    end else if (cs_rise && frame_ok &&
                 rx_r[asps_pkg::CMD_OP_LSB +: 7] ==
                 asps_pkg::CMD_WRITE_HWORD) begin
      if (cmd_addr == asps_pkg::ADDR_INPUT_CTRL) begin
        in_proto_r <= asps_pkg::asps_proto_t'(
          cmd_data[asps_pkg::IN_PROTO_LSB +: 2]);
      end
      if (cmd_addr == asps_pkg::ADDR_OUTPUT_CTRL) begin
        out_proto_r <= cmd_data[asps_pkg::OUT_PROTO_LSB +: 2];
        sec_cfg_r <= cmd_data[asps_pkg::SEC_CFG_LSB +: 2];
        clk_src_r <= cmd_data[asps_pkg::CLK_SRC_BIT];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_word <= '0;
      cmd_valid <= 1'h0;
    end else begin
      cmd_valid <= cs_rise && frame_ok;
      if (cs_rise && frame_ok) begin
        cmd_word <= rx_r;
      end
    end
  end

  assign input_protocol_sel = in_proto_r;
  assign output_protocol_sel = out_proto_r;
  assign second_output_cfg = sec_cfg_r;
  assign srcsync_clock_source = clk_src_r;

  property p_reset_default;
    @(posedge core_clk)
    reset |=> (in_proto_r == asps_pkg::PROTO_00) && legacy && !dual;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("protocol not default after reset");

  property p_cfg_at_rise;
    @(posedge core_clk) disable iff (reset)
    $changed(in_proto_r) |-> $past(cs_rise) && $past(frame_ok);
  endproperty
  a_cfg_at_rise: assert property (p_cfg_at_rise)
    else $error("protocol changed outside frame end");

  property p_short_write_ignored;
    @(posedge core_clk) disable iff (reset)
    (cs_rise && !frame_ok) |=> $stable(in_proto_r) && !cmd_valid;
  endproperty
  a_short_write_ignored: assert property (p_short_write_ignored)
    else $error("short frame accepted as write");
  property p_legacy_ready_low;
    @(posedge core_clk) disable iff (reset)
    legacy |-> !ready_out_clock_pin;
  endproperty
  a_legacy_ready_low: assert property (p_legacy_ready_low)
    else $error("ready pin high in legacy protocol");
  property p_idle_no_drive;
    @(posedge core_clk) disable iff (reset)
    convert_select_pin |-> !data_out_line0_oe && !data_out_line0;
  endproperty
  a_idle_no_drive: assert property (p_idle_no_drive)
    else $error("data driven outside frame");
  property p_word_pack;
    @(posedge core_clk) disable iff (reset)
    (cs_s && cs_d_r && !tag_address_en && tag_supply_alarm_en &&
     !tag_input_alarm_en && tag_range_en && tag_parity_en) |=>
    word_r == {$past(conv_result), $past(supply_alarm),
               $past(input_range), $past(parity_bits), 10'h000};
  endproperty
  a_word_pack: assert property (p_word_pack)
    else $error("output word packed wrongly");
  property p_alarm_pin;
    @(posedge core_clk) disable iff (reset)
    !dual |-> shared_alarm_out_pin == alarm_level;
  endproperty
  a_alarm_pin: assert property (p_alarm_pin)
    else $error("shared pin not alarm in single mode");

  sequence s_int_high;
    int_run_r && int_clk_r;
  endsequence

  property p_int_clock;
    @(posedge core_clk) disable iff (reset)
    (src_int && int_run_r && !int_clk_r && !cs_s &&
     int_idx_r < asps_pkg::WORD_BITS) |=> s_int_high ##0 ready_out_clock_pin;
  endproperty
  a_int_clock: assert property (p_int_clock)
    else $error("internal output clock did not toggle");

endmodule // asps_protocol_select

// [asps_host_model.sv]
`timescale 1ns/1ps
module asps_host_model (
  output logic link_clk,
  output logic convert_select_pin,
  output logic serial_data_in,
  input wire logic data_out_line0,
  input wire logic shared_alarm_out_pin
);
  logic [63:0] rx_word;
  logic dual_r;

  initial begin
    link_clk = 1'b0;
    convert_select_pin = 1'b1;
    serial_data_in = 1'b0;
    rx_word = '0;
    dual_r = 1'b0;
  end

  task automatic take();
    if (dual_r) begin
      rx_word = {rx_word[61:0], data_out_line0, shared_alarm_out_pin};
    end else begin
      rx_word = {rx_word[62:0], data_out_line0};
    end
  endtask

  task automatic frame(input logic [1:0] proto, input int nclk,
      input logic [63:0] tx, input logic dual);
    logic lead_cap;
    lead_cap = ~proto[0];
    dual_r = dual;
    rx_word = '0;
    link_clk = proto[1];
    #32;
    convert_select_pin = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      if (lead_cap) serial_data_in = tx[63-i];
      #32;
      if (lead_cap) take();
      link_clk = ~proto[1];
      if (!lead_cap) serial_data_in = tx[63-i];
      #32;
      if (!lead_cap) take();
      link_clk = proto[1];
    end
    #32;
    convert_select_pin = 1'b1;
    // Released line shows no stale value
    serial_data_in = ~serial_data_in;
    #120;
  endtask
endmodule // asps_host_model

// [asps_protocol_select_tb.sv]
`timescale 1ns/1ps
module asps_protocol_select_tb;
  typedef struct packed {
    logic [1:0] proto;
    logic [4:0] tags;
    logic [31:0] word;
  } asps_row_t;
  logic core_clk, reset, link_clk, convert_select_pin, serial_data_in;
  logic [asps_pkg::RES_W-1:0] conv_result;
  logic [3:0] device_addr, input_range;
  logic [1:0] supply_alarm, input_alarm, parity_bits;
  logic tag_address_en, tag_supply_alarm_en, tag_input_alarm_en;
  logic tag_range_en, tag_parity_en, alarm_level;
  logic data_out_line0, data_out_line0_oe, shared_alarm_out_pin;
  logic ready_out_clock_pin, cmd_valid, srcsync_clock_source;
  logic [31:0] cmd_word, last_cmd;
  logic [1:0] input_protocol_sel, output_protocol_sel, second_output_cfg;
  logic [1:0] cur;
  int num_errors = 0;
  int tests_run = 0;
  int cmd_cnt = 0;
  int rdy_edges = 0;
  int cyc = 0;
  asps_row_t rows [4];

  asps_protocol_select dut_u (.core_clk(core_clk), .reset(reset),
    .link_clk(link_clk), .convert_select_pin(convert_select_pin),
    .serial_data_in(serial_data_in), .conv_result(conv_result),
    .device_addr(device_addr), .supply_alarm(supply_alarm),
    .input_alarm(input_alarm), .input_range(input_range),
    .parity_bits(parity_bits), .tag_address_en(tag_address_en),
    .tag_supply_alarm_en(tag_supply_alarm_en),
    .tag_input_alarm_en(tag_input_alarm_en), .tag_range_en(tag_range_en),
    .tag_parity_en(tag_parity_en), .alarm_level(alarm_level),
    .data_out_line0(data_out_line0), .data_out_line0_oe(data_out_line0_oe),
    .shared_alarm_out_pin(shared_alarm_out_pin),
    .ready_out_clock_pin(ready_out_clock_pin), .cmd_word(cmd_word),
    .cmd_valid(cmd_valid), .input_protocol_sel(input_protocol_sel),
    .output_protocol_sel(output_protocol_sel),
    .second_output_cfg(second_output_cfg),
    .srcsync_clock_source(srcsync_clock_source));

  asps_host_model host_u (.link_clk(link_clk),
    .convert_select_pin(convert_select_pin),
    .serial_data_in(serial_data_in), .data_out_line0(data_out_line0),
    .shared_alarm_out_pin(shared_alarm_out_pin));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      cmd_cnt++;
      last_cmd = cmd_word;
    end
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  always @(posedge ready_out_clock_pin) rdy_edges++;

  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] cmd_of(logic [7:0] a, logic [15:0] d);
    return {asps_pkg::CMD_WRITE_HWORD, a, 1'b0, d};
  endfunction

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    int n;
    n = cmd_cnt;
    host_u.frame(cur, 32, {cmd_of(addr, data), 32'h0000_0000}, 1'b0);
    chk(cmd_cnt, n + 1);
    chk(last_cmd, cmd_of(addr, data));
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    cur = 2'h0;
  endtask

  initial begin
    reset = 1'b1;
    conv_result = 14'h1234;
    device_addr = 4'hA;
    supply_alarm = 2'h1;
    input_alarm = 2'h2;
    input_range = 4'h6;
    parity_bits = 2'h3;
    {tag_address_en, tag_supply_alarm_en, tag_input_alarm_en} = 3'h0;
    {tag_range_en, tag_parity_en} = 2'h0;
    alarm_level = 1'b1;
    rows[0] = '{2'h1, 5'h0B, 32'h48D1_6C00};
    rows[1] = '{2'h2, 5'h1F, 32'h48D2_99B0};
    rows[2] = '{2'h3, 5'h00, 32'h48D0_0000};
    rows[3] = '{2'h0, 5'h14, 32'h48D2_A000};
    do_reset();
    chk({input_protocol_sel, output_protocol_sel, second_output_cfg,
      srcsync_clock_source}, 7'h00);
    chk({ready_out_clock_pin, cmd_valid, data_out_line0_oe,
      data_out_line0}, 4'h0);
    chk(shared_alarm_out_pin, 1'b1);
    foreach (rows[i]) begin
      @(posedge core_clk);
      {tag_address_en, tag_supply_alarm_en, tag_input_alarm_en, tag_range_en,
        tag_parity_en} <= rows[i].tags;
      wr(asps_pkg::ADDR_INPUT_CTRL, {14'h0000, rows[i].proto});
      cur = rows[i].proto;
      chk(input_protocol_sel, rows[i].proto);
      rdy_edges = 0;
      host_u.frame(cur, 32, 64'h0, 1'b0);
      chk(host_u.rx_word[31:0], rows[i].word);
      chk(rdy_edges, 0);
    end
    // Short frame carrying a write is only a partial read
    host_u.frame(cur, 8, {cmd_of(asps_pkg::ADDR_INPUT_CTRL, 16'h0003),
      32'h0}, 1'b0);
    chk(host_u.rx_word[7:0], 8'h48);
    chk(input_protocol_sel, 2'h0);
    host_u.frame(cur, 64, 64'h5A5A_0F0F_0000_0000, 1'b0);
    chk(host_u.rx_word, 64'h48D2_A000_5A5A_0F0F);
    wr(asps_pkg::ADDR_OUTPUT_CTRL, 16'h0300);
    chk(second_output_cfg, 2'h3);
    host_u.frame(cur, 16, 64'h0, 1'b1);
    chk(host_u.rx_word[31:0], 32'h48D2_A000);
    wr(asps_pkg::ADDR_OUTPUT_CTRL, 16'h0001);
    chk(output_protocol_sel, 2'h1);
    rdy_edges = 0;
    host_u.frame(cur, 32, 64'h0, 1'b0);
    chk(rdy_edges, 32);
    chk(host_u.rx_word[31:0], 32'h48D2_A000);
    wr(asps_pkg::ADDR_OUTPUT_CTRL, 16'h0341);
    chk(srcsync_clock_source, 1'b1);
    rdy_edges = 0;
    host_u.frame(cur, 16, 64'h0, 1'b0);
    chk(rdy_edges, 16);
    do_reset();
    chk({input_protocol_sel, output_protocol_sel, second_output_cfg,
      srcsync_clock_source}, 7'h00);
    host_u.frame(cur, 32, 64'h0, 1'b0);
    chk(host_u.rx_word[31:0], 32'h48D2_A000);
    report_and_stop();
  end
endmodule // asps_protocol_select_tb
